// ==== verilog/cbio_core.sv ====
// external bus sequencer with flag and sense handling
`timescale 1ns/100ps
`default_nettype none
// Operation
// - high reset pulse resets the device
// - low hold input suspends bus sequencing
// - address_float_in high floats address outputs
// - databus_float_in high floats data lines
// - write cycles issue high write_strobe pulse
// - flag pin mirrors status word bit
// - flag change lands in final cycle
// - sense bit always follows input pin
// - non-extended i/o moves exactly one byte
// - read data/control differ only in select
// - write data/control differ only in select
// - one-byte i/o: io, non-extended, no address
// - read_write_select low read, high write
// - control write encodes io, write, ne, control
// - read_extended drives device address, loads data
// - write_extended drives address and data together
// - extended: address held through whole request
// - wait in second state until acknowledge low
module cbio_core (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        reset_in,
   // execution unit side
   input  wire logic        op_start,
   input  wire logic [2:0]  op_kind,
   input  wire logic [14:0] op_addr,
   input  wire logic [7:0]  op_wdata,
   output logic             op_done_ff,
   output logic [7:0]       op_rdata_ff,
   input  wire logic        halt_req,
   input  wire logic [1:0]  flag_op,
   input  wire logic        flag_val,
   output logic             sense_bit_ff,
   output logic             busy_ff,
   // control pins
   input  wire logic        hold_execution_in,
   input  wire logic        address_float_in,
   input  wire logic        databus_float_in,
   input  wire logic        operation_acknowledge,
   input  wire logic        direct_input_bit,
   input  wire logic        interrupt_request_n,
   input  wire logic        int_ack_cycle,
   output logic             interrupt_acknowledge_ff,
   output logic             operation_request_ff,
   output logic             memory_io_select_ff,
   output logic             read_write_select_ff,
   output logic             extended_select_ff,
   output logic             data_control_select_ff,
   output logic             write_strobe,
   output logic             direct_output_bit_ff,
   output logic             running_indicator_ff,
   // address and data pins
   output logic [12:0]      address_lines_low_ff,
   output logic             address_oe_ff,
   input  wire logic [7:0]  data_lines_in,
   output logic [7:0]       data_lines_out_ff,
   output logic             data_lines_oe_ff
);
   // ******************************************************************
   // reset synchroniser
   // ******************************************************************
   logic rs1_ff, rs2_ff;
   wire logic arst_b = rst_b & ~reset_in;
   always_ff @(posedge sys_clk or negedge arst_b) begin
      if (!arst_b) begin
         rs1_ff <= 1'b0;
         rs2_ff <= 1'b0;
      end else begin
         rs1_ff <= 1'b1;
         rs2_ff <= rs1_ff;
      end
   end
   wire logic rstn = rs2_ff;

   // ******************************************************************
   // bus cycle state machine
   // ******************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_T1   = 4'b0010,
      ST_T2   = 4'b0100,
      ST_T3   = 4'b1000
   } cbio_st_e;
   cbio_st_e st_ff, nxt_st;

   function automatic logic is_write(input logic [2:0] k);
      is_write = (k == cbio_pkg::OP_MEM_WR) || (k == cbio_pkg::OP_WR_CTRL) ||
                 (k == cbio_pkg::OP_WR_DATA) || (k == cbio_pkg::OP_WR_EXT);
   endfunction
   function automatic logic is_mem(input logic [2:0] k);
      is_mem = (k == cbio_pkg::OP_MEM_RD) || (k == cbio_pkg::OP_MEM_WR);
   endfunction
   function automatic logic is_ext(input logic [2:0] k);
      is_ext = (k == cbio_pkg::OP_RD_EXT) || (k == cbio_pkg::OP_WR_EXT);
   endfunction

   logic [2:0]  kind_ff;
   logic        ack_seen;
   wire logic   start_ok = op_start & hold_execution_in & (st_ff == ST_IDLE);
   // acknowledge sampled while in the second state
   assign ack_seen = (st_ff == ST_T2) & ~operation_acknowledge;

   // next state; the hold input only blocks new cycles so a bus cycle in
   // flight is never torn down half way
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: if (start_ok) nxt_st = ST_T1;
         ST_T1:   nxt_st = ST_T2;
         ST_T2:   if (ack_seen) nxt_st = ST_T3;
         ST_T3:   nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) st_ff <= ST_IDLE;
      else st_ff <= nxt_st;
   end

   // ******************************************************************
   // pin encoding for the captured operation
   // ******************************************************************
   wire logic       cur_wr   = is_write(op_kind);
   wire logic       cur_mem  = is_mem(op_kind);
   wire logic       cur_ext  = is_ext(op_kind);
   wire logic       cur_dc   = (op_kind == cbio_pkg::OP_RD_DATA) ||
                               (op_kind == cbio_pkg::OP_WR_DATA);
   // memory uses bits 13 and 14 as address
   // one-byte io: non-extended, select valid, address zero
   // extended: second byte on low address lines
   wire logic [12:0] cur_adr = cur_mem ? op_addr[12:0] :
                               cur_ext ? {5'h00, op_addr[7:0]} : 13'h0000;
   wire logic       cur_e    = cur_mem ? op_addr[13] :
                               (cur_ext ? cbio_pkg::EXT_EXT : cbio_pkg::EXT_NONE);
   // data/control is a don't-care on extended cycles, held at data
   // read data versus control only in this select
   wire logic       cur_d    = cur_mem ? op_addr[14] :
                               (cur_ext | cur_dc ? cbio_pkg::DC_DATA : cbio_pkg::DC_CTRL);

   // control write: io, write, non-extended, control
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         kind_ff                <= 3'h0;
         memory_io_select_ff    <= cbio_pkg::MIO_MEM;
         read_write_select_ff   <= cbio_pkg::RW_READ;
         extended_select_ff     <= cbio_pkg::EXT_NONE;
         data_control_select_ff <= cbio_pkg::DC_CTRL;
         data_lines_out_ff      <= cbio_pkg::DATA_RST;
      end else if (start_ok) begin
         kind_ff                <= op_kind;
         memory_io_select_ff    <= cur_mem ? cbio_pkg::MIO_MEM : cbio_pkg::MIO_IO;
         read_write_select_ff   <= cur_wr ? cbio_pkg::RW_WRITE : cbio_pkg::RW_READ;
         extended_select_ff     <= cur_e;
         data_control_select_ff <= cur_d;
         data_lines_out_ff      <= op_wdata;
      end
   end

   // ******************************************************************
   // request, data capture and completion
   // ******************************************************************
   wire logic wr_cur = is_write(kind_ff);
   // one byte per operation, request drops after acknowledge
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         operation_request_ff     <= 1'b0;
         interrupt_acknowledge_ff <= 1'b0;
         op_rdata_ff              <= cbio_pkg::DATA_RST;
         op_done_ff               <= 1'b0;
         busy_ff                  <= 1'b0;
      end else begin
         operation_request_ff     <= (nxt_st == ST_T1) | (nxt_st == ST_T2);
         if (start_ok) interrupt_acknowledge_ff <= int_ack_cycle;
         else if (st_ff == ST_T3) interrupt_acknowledge_ff <= 1'b0;
         op_done_ff <= ack_seen;
         busy_ff    <= nxt_st != ST_IDLE;
         if (ack_seen && !wr_cur) op_rdata_ff <= data_lines_in;
      end
   end

   // strobe fired on acknowledge of a write
   cbio_wrp_gen u_wrp (
      .clk      (sys_clk),
      .rst_b    (rstn),
      .fire     (ack_seen & wr_cur),
      .pulse_ff (write_strobe)
   );

   // ******************************************************************
   // pin drivers, flag, sense and run indicator
   // ******************************************************************
   // address float
   // write data driven one cycle behind the request, from the second state through the third
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         address_lines_low_ff <= 13'h0000;
         address_oe_ff        <= 1'b0;
         data_lines_oe_ff     <= 1'b0;
      end else begin
         // loaded with the start so the address stands for the whole request
         if (start_ok) address_lines_low_ff <= cur_adr;
         address_oe_ff        <= ~address_float_in;
         data_lines_oe_ff     <= ~databus_float_in & wr_cur &
                                 ((st_ff == ST_T1) | (st_ff == ST_T2));
      end
   end

   // flag pin mirrors the status bit
   // update taken in the instruction's final cycle
   // sense follows the pin every cycle
   // run high unless halted or held
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         direct_output_bit_ff <= cbio_pkg::FLAG_RST;
         sense_bit_ff         <= 1'b0;
         running_indicator_ff <= 1'b0;
      end else begin
         case (flag_op)
            cbio_pkg::FL_LOAD:   direct_output_bit_ff <= flag_val;
            cbio_pkg::FL_PRESET: direct_output_bit_ff <= 1'b1;
            cbio_pkg::FL_CLEAR:  direct_output_bit_ff <= 1'b0;
            default:             direct_output_bit_ff <= direct_output_bit_ff;
         endcase
         sense_bit_ff         <= direct_input_bit;
         running_indicator_ff <= hold_execution_in & ~halt_req;
      end
   end

   // ******************************************************************
   // assertions
   // ******************************************************************
   sequence s_wait_ack;
      (st_ff == ST_T2) && operation_acknowledge;
   endsequence
   a_wait_in_t2: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_wait_ack |=> (st_ff == ST_T2)) else $error("left t2 without ack");
   a_start_held: assert property (@(posedge sys_clk) disable iff (!rstn)
      (op_start && !hold_execution_in && st_ff == ST_IDLE) |=> st_ff == ST_IDLE)
      else $error("cycle started while held");
   a_addr_float: assert property (@(posedge sys_clk) disable iff (!rstn)
      address_float_in |=> !address_oe_ff) else $error("address driven while floated");
   a_data_float: assert property (@(posedge sys_clk) disable iff (!rstn)
      databus_float_in |=> !data_lines_oe_ff) else $error("data driven while floated");
   a_wrp_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ack_seen && wr_cur) |=> write_strobe [*2] ##1 !write_strobe)
      else $error("write strobe width wrong");
   a_flag_preset: assert property (@(posedge sys_clk) disable iff (!rstn)
      flag_op == cbio_pkg::FL_PRESET |=> direct_output_bit_ff) else $error("flag not set");
   a_sense_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(rstn) |-> sense_bit_ff == $past(direct_input_bit))
      else $error("sense not following pin");
   a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rstn)
      (start_ok && op_kind == cbio_pkg::OP_WR_CTRL) |=> ##1 (operation_request_ff &&
      !memory_io_select_ff && read_write_select_ff && !extended_select_ff &&
      !data_control_select_ff)) else $error("control write encoding wrong");
   a_ext_addr_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      (operation_request_ff && extended_select_ff && !memory_io_select_ff &&
       $past(operation_request_ff)) |-> $stable(address_lines_low_ff))
      else $error("extended address moved");
   a_one_request: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st_ff == ST_T3) |=> !operation_request_ff) else $error("request not dropped");
   // pin encoding and drive once a cycle has been taken
   a_addr_early: assert property (@(posedge sys_clk) disable iff (!rstn)
      start_ok |=> address_lines_low_ff == $past(cur_adr)) else $error("address late");
   a_io_one_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
      (start_ok && !cur_mem && !cur_ext) |=> (memory_io_select_ff == cbio_pkg::MIO_IO &&
      extended_select_ff == cbio_pkg::EXT_NONE && address_lines_low_ff == 13'h0000))
      else $error("one byte io encoding wrong");
   a_mem_bits: assert property (@(posedge sys_clk) disable iff (!rstn)
      (start_ok && cur_mem) |=> (extended_select_ff == $past(op_addr[13]) &&
      data_control_select_ff == $past(op_addr[14]))) else $error("memory high bits wrong");
   a_rw_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      start_ok |=> read_write_select_ff == $past(cur_wr)) else $error("direction wrong");
   a_rd_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ack_seen && !wr_cur) |=> op_rdata_ff == $past(data_lines_in))
      else $error("read byte not captured");
   a_strobe_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ack_seen && !wr_cur) |=> !write_strobe) else $error("strobe on a read");
   a_ext_oe: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st_ff == ST_T2 && wr_cur && !databus_float_in) |=> data_lines_oe_ff)
      else $error("write data not driven");
   a_float_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
      !address_float_in |=> address_oe_ff) else $error("address not driven");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      flag_op == cbio_pkg::FL_CLEAR |=> !direct_output_bit_ff) else $error("flag not cleared");
   a_run_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!hold_execution_in || halt_req) |=> !running_indicator_ff)
      else $error("running while waiting");
   a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
      op_done_ff |=> !op_done_ff) else $error("done longer than one cycle");
endmodule
`default_nettype wire

// ==== verilog/cbio_pkg.sv ====
// constants shared by the cpu bus and i/o signalling block
package cbio_pkg;
   // ******************************************************************
   // pin levels
   // ******************************************************************
   localparam logic MIO_MEM     = 1'b1;
   localparam logic MIO_IO      = 1'b0;
   localparam logic RW_READ     = 1'b0;
   localparam logic RW_WRITE    = 1'b1;
   localparam logic EXT_NONE    = 1'b0;
   localparam logic EXT_EXT     = 1'b1;
   localparam logic DC_CTRL     = 1'b0;
   localparam logic DC_DATA     = 1'b1;
   // ******************************************************************
   // operation kinds presented by the user side
   // ******************************************************************
   localparam logic [2:0] OP_MEM_RD  = 3'h0;
   localparam logic [2:0] OP_MEM_WR  = 3'h1;
   localparam logic [2:0] OP_RD_CTRL = 3'h2;
   localparam logic [2:0] OP_RD_DATA = 3'h3;
   localparam logic [2:0] OP_WR_CTRL = 3'h4;
   localparam logic [2:0] OP_WR_DATA = 3'h5;
   localparam logic [2:0] OP_RD_EXT  = 3'h6;
   localparam logic [2:0] OP_WR_EXT  = 3'h7;
   // ******************************************************************
   // status flag update kinds
   // ******************************************************************
   localparam logic [1:0] FL_NONE   = 2'h0;
   localparam logic [1:0] FL_LOAD   = 2'h1;
   localparam logic [1:0] FL_PRESET = 2'h2;
   localparam logic [1:0] FL_CLEAR  = 2'h3;
   // ******************************************************************
   // widths, reset values and timing
   // ******************************************************************
   localparam int         ADR_W       = 15;
   localparam logic [14:0] ADR_RST    = 15'h0000;
   localparam logic [7:0]  DATA_RST   = 8'h00;
   localparam logic        FLAG_RST   = 1'b0;
   localparam int          CLK_MHZ    = 50;
   localparam int          WRP_NS     = 40;
   localparam int          WRP_CYC    = (WRP_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== verilog/cbio_wrp_gen.sv ====
// write strobe pulse generator of fixed width
`timescale 1ns/100ps
`default_nettype none
module cbio_wrp_gen (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // control
   input  wire logic fire,
   output var  logic pulse_ff
);
   logic [3:0] cnt_ff;
   wire logic  last = (cnt_ff == 4'h1);

   // count down the strobe width
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff   <= 4'h0;
         pulse_ff <= 1'b0;
      end else if (fire) begin
         cnt_ff   <= 4'(cbio_pkg::WRP_CYC);
         pulse_ff <= 1'b1;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff   <= cnt_ff - 4'h1;
         pulse_ff <= !last;
      end
   end
endmodule
`default_nettype wire

// ==== test/cbio_periph_model.sv ====
// memory and i/o peripheral that answers bus cycles of the core
`timescale 1ns/100ps
`default_nettype none
module cbio_periph_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // bus from the core
   input  wire logic       operation_request,
   input  wire logic       read_write_select,
   input  wire logic       write_strobe,
   input  wire logic [7:0] data_lines,
   // answer settings from the bench
   input  wire logic [3:0] ack_dly,
   input  wire logic [7:0] rd_value,
   // answer to the core
   output logic            operation_acknowledge,
   output logic [7:0]      data_lines_in,
   output logic [7:0]      wr_byte
);
   int   cnt;
   logic strobe_q;

   // selects used only under request, ack after a set delay
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt = 0;
         operation_acknowledge <= 1'b1;
         data_lines_in <= 8'h5a;
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= write_strobe;
         if (!operation_request) begin
            cnt = 0;
            operation_acknowledge <= 1'b1;
         end else if (cnt >= ack_dly) begin
            operation_acknowledge <= 1'b0;
         end else begin
            cnt = cnt + 1;
         end
         // released bus toggles so a stale byte is never mistaken for data
         if (operation_request && read_write_select == cbio_pkg::RW_READ) begin
            data_lines_in <= rd_value;
         end else begin
            data_lines_in <= ~data_lines_in;
         end
         if (write_strobe && !strobe_q) begin
            wr_byte <= data_lines;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the cpu bus and i/o signalling core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   // ******************************************************************
   // signals
   // ******************************************************************
   logic        sys_clk, rst_b, reset_in, op_start, halt_req, flag_val, hold_execution_in;
   logic        address_float_in, databus_float_in, direct_input_bit, int_ack_cycle;
   logic [2:0]  op_kind;
   logic [14:0] op_addr;
   logic [7:0]  op_wdata, rd_value, data_lines_in, op_rdata_ff, data_lines_out_ff, wr_byte;
   logic [1:0]  flag_op;
   logic [3:0]  ack_dly;
   logic        op_done_ff, sense_bit_ff, busy_ff, operation_acknowledge;
   logic        interrupt_acknowledge_ff, operation_request_ff, memory_io_select_ff;
   logic        read_write_select_ff, extended_select_ff, data_control_select_ff;
   logic        write_strobe, direct_output_bit_ff, running_indicator_ff;
   logic        address_oe_ff, data_lines_oe_ff;
   logic [12:0] address_lines_low_ff;
   int          fail_count, compares, flag_m;
   logic [7:0]  exp_wr[$];

   // no interrupt is raised, so the request line stays released
   cbio_core u_cbio_core (.sys_clk, .rst_b, .reset_in, .op_start, .op_kind, .op_addr,
      .op_wdata, .op_done_ff, .op_rdata_ff, .halt_req, .flag_op, .flag_val, .sense_bit_ff,
      .busy_ff, .hold_execution_in, .address_float_in, .databus_float_in,
      .operation_acknowledge, .direct_input_bit, .interrupt_request_n(1'b1),
      .int_ack_cycle, .interrupt_acknowledge_ff, .operation_request_ff,
      .memory_io_select_ff, .read_write_select_ff, .extended_select_ff,
      .data_control_select_ff, .write_strobe, .direct_output_bit_ff,
      .running_indicator_ff, .address_lines_low_ff, .address_oe_ff, .data_lines_in,
      .data_lines_out_ff, .data_lines_oe_ff);

   cbio_periph_model u_cbio_periph_model (.sys_clk, .rst_b,
      .operation_request(operation_request_ff), .read_write_select(read_write_select_ff),
      .write_strobe, .data_lines(data_lines_oe_ff ? data_lines_out_ff : ~data_lines_out_ff),
      .ack_dly, .rd_value, .operation_acknowledge, .data_lines_in, .wr_byte);

   // clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end

   task automatic summarize;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one bus cycle of kind k, checked against the signalling table
   task automatic run_op(input logic [2:0] k, input logic af, input logic df, input logic ia);
      logic [14:0] a;
      logic [7:0]  w, r, x;
      logic        wr, mem, ext;
      int          n, wp, d;
      a = 15'($urandom);
      w = 8'($urandom);
      r = 8'($urandom);
      d = $urandom_range(5, 0);
      wr = k inside {3'h1, 3'h4, 3'h5, 3'h7};
      mem = k <= cbio_pkg::OP_MEM_WR;
      ext = k >= cbio_pkg::OP_RD_EXT;
      if (wr && !df) exp_wr.push_back(w);
      @(posedge sys_clk);
      op_start <= 1'b1;
      op_kind <= k;
      op_addr <= a;
      op_wdata <= w;
      rd_value <= r;
      ack_dly <= 4'(d);
      address_float_in <= af;
      databus_float_in <= df;
      int_ack_cycle <= ia;
      @(posedge sys_clk);
      op_start <= 1'b0;
      wp = 0;
      for (n = 1; n < 60; n++) begin
         @(posedge sys_clk);
         #1;
         if (write_strobe === 1'b1) wp++;
         // request and address stand from the first cycle of the operation
         if (n == 1) begin
            `CHK("request", 1'b1, operation_request_ff)
            `CHK("busy", 1'b1, busy_ff)
            `CHK("adr_early", mem | ext ? a[7:0] : 8'h00, address_lines_low_ff[7:0])
         end
         if (op_done_ff === 1'b1) break;
      end
      `CHK("op_done", 1'b1, op_done_ff)
      // done shows two edges after the start plus one per cycle of ack delay
      `CHK("ack_wait", d + 2, n)
      `CHK("req_low", 1'b0, operation_request_ff)
      `CHK("mio", mem ? cbio_pkg::MIO_MEM : cbio_pkg::MIO_IO, memory_io_select_ff)
      `CHK("rw", wr, read_write_select_ff)
      `CHK("ext_sel", mem ? a[13] : ext, extended_select_ff)
      `CHK("dc_sel", mem ? a[14] : (ext | k[0]), data_control_select_ff)
      `CHK("adr_low", mem | ext ? a[7:0] : 8'h00, address_lines_low_ff[7:0])
      if (mem) `CHK("adr_high", a[12:8], address_lines_low_ff[12:8])
      `CHK("adr_oe", ~af, address_oe_ff)
      `CHK("data_oe", wr & ~df, data_lines_oe_ff)
      `CHK("int_ack", ia, interrupt_acknowledge_ff)
      repeat (3) begin
         @(posedge sys_clk);
         #1;
         if (write_strobe === 1'b1) wp++;
      end
      `CHK("strobe_len", wr ? cbio_pkg::WRP_CYC : 0, wp)
      `CHK("req_drop", 1'b0, operation_request_ff)
      `CHK("idle", 1'b0, busy_ff)
      if (!wr) `CHK("rdata", r, op_rdata_ff)
      else if (!df) begin
         // popped once so a mismatch report cannot drain the queue
         x = exp_wr.pop_front();
         `CHK("wdata", x, wr_byte)
      end
   endtask

   // one status flag command, model updated alongside
   task automatic set_flag(input logic [1:0] op, input logic v);
      @(posedge sys_clk);
      flag_op <= op;
      flag_val <= v;
      if (op == cbio_pkg::FL_LOAD) flag_m = v;
      else if (op == cbio_pkg::FL_PRESET) flag_m = 1;
      else if (op == cbio_pkg::FL_CLEAR) flag_m = 0;
      @(posedge sys_clk);
      flag_op <= cbio_pkg::FL_NONE;
      #1 `CHK("flag", flag_m[0], direct_output_bit_ff)
   endtask

   // ******************************************************************
   // main sequence
   // ******************************************************************
   initial begin
      void'($urandom(32'h62bcfaaf));
      {rst_b, reset_in, op_start, halt_req, flag_val, int_ack_cycle} = 6'h00;
      {address_float_in, databus_float_in, direct_input_bit} = 3'h0;
      hold_execution_in = 1'b1;
      {op_kind, op_addr, op_wdata, rd_value, flag_op, ack_dly} = '0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1 `CHK("rst_mio", cbio_pkg::MIO_MEM, memory_io_select_ff)
      `CHK("rst_req", 1'b0, operation_request_ff)
      repeat (4) @(posedge sys_clk);
      #1 `CHK("running", 1'b1, running_indicator_ff)
      for (int i = 0; i < 24; i++) run_op(3'(i), i >= 16 && i[0], i >= 16 && i[1], i[3] & i[0]);
      // a start under hold must not open a cycle
      @(posedge sys_clk);
      hold_execution_in <= 1'b0;
      op_start <= 1'b1;
      repeat (6) begin
         @(posedge sys_clk);
         #1 `CHK("held", 1'b0, operation_request_ff)
      end
      op_start <= 1'b0;
      @(posedge sys_clk);
      hold_execution_in <= 1'b1;
      set_flag(cbio_pkg::FL_LOAD, 1'b1);
      set_flag(cbio_pkg::FL_CLEAR, 1'b1);
      set_flag(cbio_pkg::FL_NONE, 1'b1);
      set_flag(cbio_pkg::FL_PRESET, 1'b0);
      set_flag(cbio_pkg::FL_LOAD, 1'b0);
      set_flag(cbio_pkg::FL_PRESET, 1'b0);
      // sense pin followed one cycle later
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         direct_input_bit <= 1'($urandom);
         @(posedge sys_clk);
         #1 `CHK("sense", direct_input_bit, sense_bit_ff)
      end
      @(posedge sys_clk);
      halt_req <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 `CHK("waiting", 1'b0, running_indicator_ff)
      halt_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 `CHK("resumed", 1'b1, running_indicator_ff)
      // reset pin pulse in mid-run clears the flag
      reset_in <= 1'b1;
      @(posedge sys_clk);
      #1 `CHK("pulse_flag", 1'b0, direct_output_bit_ff)
      `CHK("pulse_mio", cbio_pkg::MIO_MEM, memory_io_select_ff)
      reset_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      run_op(cbio_pkg::OP_WR_DATA, 1'b0, 1'b0, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
